// ==== hw/absence_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module absence_monitor
  import clkgen_pkg::*;
(
  input wire logic aclk,
  input wire logic core_rst,
  input wire logic enable,
  input wire logic tick,
  input wire logic [15:0] threshold,
  input wire clkgen_pkg::val_count_t val_cycles,
  output logic absent
);
  logic [15:0] gap;
  val_count_t valid;
  // Gap saturates so a dead clock never wraps back to looking alive
  always_ff @(posedge aclk) begin
    if (core_rst || !enable) begin
      gap <= 16'h0000;
      valid <= '0;
      absent <= 1'b0;
    end else begin
      if (tick) begin
        gap <= 16'h0000;
      end else if (gap != 16'hFFFF) begin
        gap <= gap + 16'h0001;
      end
      if (!absent) begin
        absent <= (gap >= threshold);
      end else if (gap >= threshold) begin
        valid <= '0;
      end else if (valid + 28'h0000001 >= val_cycles) begin
        absent <= 1'b0;
        valid <= '0;
      end else begin
        valid <= valid + 28'h0000001;
      end
    end
  end
  clear_after_valid_a: assert property (@(posedge aclk) disable iff (core_rst)
    $fell(absent) && $past(enable) |-> $past(valid) + 28'h0000001 >= $past(val_cycles))
    else $error("absence cleared before validation time");
endmodule // absence_monitor
`default_nettype wire

// ==== hw/clkgen_ctrl.sv ====
// Summary of operation
// - Writing 1 to step bit 0 launches one upward frequency step pulse.
// - Writing 1 to step bit 1 launches one downward frequency step pulse.
// - Control bit 0 set holds the low power request for as long.
// - Hard reset bit resets core and reloads config; register port stays alive.
// - Hard reset bit never self-clears; software must write it back to 0.
// - Control bit 2 pulses divider sync exactly like the external sync pin.
// - Selection-source bit 0 picks pins, 1 picks the register field.
// - Register field 0..2 choose inputs zero to two, 3 the crystal.
// - Port-mode bit 3 gives four-wire when 0, three-wire when 1.
// - Enable bits 3:0 turn on absence detection for inputs 0-2 and feedback.
// - Enable bit 4 is inverted: 0 enables crystal absence detection.
// - An alarm clears after the clock stays good for the validation time, or at once when its detection is disabled.
// - Validation field pairs 1:0, 3:2, 5:4 serve inputs zero, one, two.
// - Each main input has a 16-bit threshold, low byte first address.
// - Pre-divider code n divides by two to the n, codes above 16 act as 16; 0 bypasses.
// - Four pre-divider bytes: inputs zero, one, two, then feedback.
// - Live absence bits follow the condition; sticky bits clear on written 0.
//
// Added by the designer: register access over AXI4-Lite.
`include "clkgen_params.svh"
`timescale 1ns/100ps
`default_nettype none
module clkgen_ctrl
  import clkgen_pkg::*;
#(
  parameter int VAL_CYCLES0 = `VAL_TIME0_MS * `CLK_KHZ,
  parameter int VAL_CYCLES1 = `VAL_TIME1_MS * `CLK_KHZ,
  parameter int VAL_CYCLES2 = `VAL_TIME2_MS * `CLK_KHZ,
  parameter int VAL_CYCLES3 = `VAL_TIME3_MS * `CLK_KHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output clkgen_pkg::axi_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output clkgen_pkg::axi_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ref_choice_pin_high,
  input wire logic ref_choice_pin_low,
  input wire logic ext_sync_pin,
  input wire logic ref_input_zero,
  input wire logic ref_input_one,
  input wire logic ref_input_two,
  input wire logic feedback_input,
  input wire logic crystal_input,
  output logic freq_step_up,
  output logic freq_step_down,
  output logic low_power_request,
  output logic device_hard_reset,
  output logic nvm_reload_request,
  output logic r_divider_sync,
  output logic [1:0] pll_ref_select,
  output logic serial_three_wire_mode,
  output logic [4:0] signal_absent_status,
  output logic irq
);
  import clkgen_pkg::*;

  logic [`AXI_ADDR_W-1:0] aw_addr_q;
  reg_byte_t w_data_q;
  logic w_lane_q;
  logic do_write;
  logic [7:0] wr_idx;
  logic wr_ok;
  reg_byte_t ctrl;
  reg_byte_t refsel;
  reg_byte_t wire_mode;
  reg_byte_t det_en;
  reg_byte_t val_time;
  reg_byte_t thr [0:5];
  reg_byte_t pdiv [0:3];
  logic [3:0] sticky;
  logic [4:0] irq_status;
  logic [4:0] irq_enable;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic core_rst;
  logic [4:0] enables;
  logic [4:0] ticks;
  logic [4:0] absent;
  logic [4:0] absent_q;
  logic [4:0] onset;
  reg_byte_t rd_val;
  logic rd_ok;
  logic [7:0] rd_idx;

  assign do_write = !awready && !wready && !bvalid;
  assign wr_idx = aw_addr_q[9:2];
  assign core_rst = !aresetn || ctrl[`BIT_HARD_RST];
  assign onset = absent & ~absent_q;

  // Write address and data are taken in either order; response once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      if (do_write) begin
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (wr_idx)
      `REG_STEP, `REG_CTRL, `REG_REFSEL, `REG_WIRE, `REG_DET_EN, `REG_VAL_TIME,
      `REG_THR0_LO, `REG_THR0_HI, `REG_THR1_LO, `REG_THR1_HI, `REG_THR2_LO,
      `REG_THR2_HI, `REG_PDIV0, `REG_PDIV1, `REG_PDIV2, `REG_PDIVFB,
      `REG_ABS_STICKY, `REG_IRQ_CLEAR, `REG_IRQ_ENABLE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Configuration stays on the bus reset only, so hard reset cannot erase itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= 8'h00;
      refsel <= 8'h00;
      wire_mode <= 8'h00;
      det_en <= 8'h00;
      val_time <= 8'h00;
      irq_enable <= 5'h00;
      for (int i = 0; i < 6; i++) begin
        thr[i] <= 8'hFF;
      end
      for (int i = 0; i < 4; i++) begin
        pdiv[i] <= 8'h00;
      end
    end else begin
      ctrl[`BIT_DIV_SYNC] <= 1'b0;
      if (do_write && w_lane_q) begin
        case (wr_idx)
          `REG_CTRL: ctrl <= w_data_q;
          `REG_REFSEL: refsel <= w_data_q;
          `REG_WIRE: wire_mode <= w_data_q;
          `REG_DET_EN: det_en <= w_data_q;
          `REG_VAL_TIME: val_time <= w_data_q;
          `REG_THR0_LO: thr[0] <= w_data_q;
          `REG_THR0_HI: thr[1] <= w_data_q;
          `REG_THR1_LO: thr[2] <= w_data_q;
          `REG_THR1_HI: thr[3] <= w_data_q;
          `REG_THR2_LO: thr[4] <= w_data_q;
          `REG_THR2_HI: thr[5] <= w_data_q;
          `REG_PDIV0: pdiv[0] <= w_data_q;
          `REG_PDIV1: pdiv[1] <= w_data_q;
          `REG_PDIV2: pdiv[2] <= w_data_q;
          `REG_PDIVFB: pdiv[3] <= w_data_q;
          `REG_IRQ_ENABLE: irq_enable <= w_data_q[4:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= {crystal_input, feedback_input, ref_input_two, ref_input_one,
                ref_input_zero, ext_sync_pin, ref_choice_pin_high, ref_choice_pin_low};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Strobes are pulses, so a stored 1 never blocks the next edge
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      freq_step_up <= 1'b0;
      freq_step_down <= 1'b0;
    end else begin
      freq_step_up <= do_write && w_lane_q && wr_idx == `REG_STEP
                      && w_data_q[`BIT_STEP_UP];
      freq_step_down <= do_write && w_lane_q && wr_idx == `REG_STEP
                        && w_data_q[`BIT_STEP_DOWN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_power_request <= 1'b0;
      device_hard_reset <= 1'b0;
      nvm_reload_request <= 1'b0;
      r_divider_sync <= 1'b0;
      pll_ref_select <= 2'h0;
      serial_three_wire_mode <= 1'b0;
    end else begin
      low_power_request <= ctrl[`BIT_LOW_POWER];
      device_hard_reset <= ctrl[`BIT_HARD_RST];
      nvm_reload_request <= ctrl[`BIT_HARD_RST] && !device_hard_reset;
      r_divider_sync <= ctrl[`BIT_DIV_SYNC] || (sync2[2] && !sync3[2]);
      pll_ref_select <= refsel[`BIT_REF_BY_REG] ? refsel[2:1] : sync2[1:0];
      serial_three_wire_mode <= wire_mode[`BIT_THREE_WIRE];
    end
  end

  assign enables = {!det_en[`BIT_XTAL_DET_OFF], det_en[3:0]};

  function automatic val_count_t val_of(input logic [1:0] code);
    case (code)
      2'h0: val_of = VAL_CYCLES0[27:0];
      2'h1: val_of = VAL_CYCLES1[27:0];
      2'h2: val_of = VAL_CYCLES2[27:0];
      default: val_of = VAL_CYCLES3[27:0];
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_in
      logic [4:0] code;
      logic [15:0] threshold;
      val_count_t val_cycles;
      if (g < 4) begin : g_pd
        assign code = (pdiv[g] > 8'(`PREDIV_MAX)) ? `PREDIV_MAX : pdiv[g][4:0];
      end else begin : g_nopd
        assign code = 5'h00;
      end
      if (g < 3) begin : g_main
        assign threshold = {thr[2*g+1], thr[2*g]};
        assign val_cycles = val_of(val_time[2*g+1 -: 2]);
      end else begin : g_aux
        assign threshold = (g == 3) ? `FB_THRESHOLD : `XTAL_THRESHOLD;
        assign val_cycles = val_of(2'h0);
      end
      prediv_counter u_pd (
        .aclk(aclk),
        .core_rst(core_rst),
        .edge_in(sync2[g+3] && !sync3[g+3]),
        .code(code),
        .tick(ticks[g])
      );
      absence_monitor u_mon (
        .aclk(aclk),
        .core_rst(core_rst),
        .enable(enables[g]),
        .tick(ticks[g]),
        .threshold(threshold),
        .val_cycles(val_cycles),
        .absent(absent[g])
      );
    end
  endgenerate

  // A new alarm in the same cycle as a clear keeps its flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      absent_q <= 5'h00;
      signal_absent_status <= 5'h00;
      sticky <= 4'h0;
      irq_status <= 5'h00;
      irq <= 1'b0;
    end else begin
      absent_q <= absent;
      signal_absent_status <= absent;
      if (do_write && w_lane_q && wr_idx == `REG_ABS_STICKY) begin
        sticky <= (sticky & w_data_q[3:0]) | onset[3:0];
      end else begin
        sticky <= sticky | onset[3:0];
      end
      if (do_write && w_lane_q && wr_idx == `REG_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~w_data_q[4:0]) | onset;
      end else begin
        irq_status <= irq_status | onset;
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  assign rd_idx = araddr[9:2];

  always_comb begin
    rd_ok = 1'b1;
    case (rd_idx)
      `REG_STEP: rd_val = 8'h00;
      `REG_CTRL: rd_val = {5'h00, 1'b0, ctrl[1:0]};
      `REG_REFSEL: rd_val = refsel;
      `REG_WIRE: rd_val = wire_mode;
      `REG_DET_EN: rd_val = det_en;
      `REG_VAL_TIME: rd_val = val_time;
      `REG_THR0_LO: rd_val = thr[0];
      `REG_THR0_HI: rd_val = thr[1];
      `REG_THR1_LO: rd_val = thr[2];
      `REG_THR1_HI: rd_val = thr[3];
      `REG_THR2_LO: rd_val = thr[4];
      `REG_THR2_HI: rd_val = thr[5];
      `REG_PDIV0: rd_val = pdiv[0];
      `REG_PDIV1: rd_val = pdiv[1];
      `REG_PDIV2: rd_val = pdiv[2];
      `REG_PDIVFB: rd_val = pdiv[3];
      `REG_ABS_STATUS: rd_val = {3'h0, signal_absent_status};
      `REG_ABS_STICKY: rd_val = {4'h0, sticky};
      `REG_IRQ_STATUS: rd_val = {3'h0, irq_status};
      `REG_IRQ_CLEAR: rd_val = 8'h00;
      `REG_IRQ_ENABLE: rd_val = {3'h0, irq_enable};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_val};
      rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  step_up_pulse_a: assert property (@(posedge aclk) disable iff (core_rst)
    do_write && w_lane_q && wr_idx == `REG_STEP && w_data_q[0] |=> freq_step_up ##1 !freq_step_up)
    else $error("step up pulse missing or too long");
  step_down_pulse_a: assert property (@(posedge aclk) disable iff (core_rst)
    freq_step_down |-> $past(do_write) && $past(w_data_q[1]) && $past(wr_idx) == `REG_STEP)
    else $error("step down pulse without a write");
  low_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[0] [*2] |-> low_power_request)
    else $error("low power request dropped while bit set");
  hard_reset_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[1] && !(do_write && wr_idx == `REG_CTRL) |=> ctrl[1] && device_hard_reset)
    else $error("hard reset cleared without a write");
  hard_reset_core_a: assert property (@(posedge aclk) disable iff (!aresetn)
    device_hard_reset |-> absent == 5'h00 && !freq_step_up && arready | rvalid)
    else $error("core active or port blocked during hard reset");
  div_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sync2[2]) |=> r_divider_sync)
    else $error("divider sync not pulsed for pin");
  ref_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    refsel[0] && $stable(refsel) |=> pll_ref_select == $past(refsel[2:1]))
    else $error("register reference choice not applied");
  three_wire_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wire_mode[3] |=> serial_three_wire_mode)
    else $error("three wire mode not followed");
  sticky_set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    onset[0] |=> sticky[0] && irq_status[0])
    else $error("absence onset lost against clear");
endmodule // clkgen_ctrl
`default_nettype wire

// ==== hw/clkgen_params.svh ====
`ifndef CLKGEN_PARAMS_SVH
`define CLKGEN_PARAMS_SVH
`define AXI_ADDR_W 10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define REG_STEP 8'h1D
`define REG_CTRL 8'h1E
`define REG_REFSEL 8'h21
`define REG_WIRE 8'h2B
`define REG_DET_EN 8'h2C
`define REG_VAL_TIME 8'h2D
`define REG_THR0_LO 8'h2E
`define REG_THR0_HI 8'h2F
`define REG_THR1_LO 8'h30
`define REG_THR1_HI 8'h31
`define REG_THR2_LO 8'h32
`define REG_THR2_HI 8'h33
`define REG_PDIV0 8'h41
`define REG_PDIV1 8'h42
`define REG_PDIV2 8'h43
`define REG_PDIVFB 8'h44
`define REG_ABS_STATUS 8'h50
`define REG_ABS_STICKY 8'h51
`define REG_IRQ_STATUS 8'h52
`define REG_IRQ_CLEAR 8'h53
`define REG_IRQ_ENABLE 8'h54
`define BIT_STEP_UP 0
`define BIT_STEP_DOWN 1
`define BIT_LOW_POWER 0
`define BIT_HARD_RST 1
`define BIT_DIV_SYNC 2
`define BIT_REF_BY_REG 0
`define BIT_THREE_WIRE 3
`define BIT_XTAL_DET_OFF 4
`define PREDIV_MAX 5'h10
`define CLK_KHZ 250000
`define VAL_TIME0_MS 2
`define VAL_TIME1_MS 100
`define VAL_TIME2_MS 200
`define VAL_TIME3_MS 1000
`define FB_THRESHOLD 16'h0100
`define XTAL_THRESHOLD 16'h0100
`endif

// ==== hw/clkgen_pkg.sv ====
`default_nettype none
package clkgen_pkg;
  typedef logic [1:0] axi_resp_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [27:0] val_count_t;
endpackage
`default_nettype wire

// ==== hw/prediv_counter.sv ====
`timescale 1ns/100ps
`default_nettype none
module prediv_counter (
  input wire logic aclk,
  input wire logic core_rst,
  input wire logic edge_in,
  input wire logic [4:0] code,
  output logic tick
);
  logic [15:0] cnt;
  logic [15:0] mask;
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_mask
      assign mask[i] = (5'(i) < code);
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= edge_in && ((cnt & mask) == mask);
      if (edge_in) begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule // prediv_counter
`default_nettype wire

// ==== verification/clkgen_ctrl_tb.sv ====
`include "clkgen_params.svh"
`timescale 1ns/100ps
`default_nettype none
module clkgen_ctrl_tb;
  import clkgen_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = '0;
  logic [9:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ref_choice_pin_high = 1'b0;
  logic ref_choice_pin_low = 1'b0;
  logic ext_sync_pin = 1'b0;
  logic ref_input_zero = 1'b0;
  logic ref_input_one = 1'b0;
  logic ref_input_two = 1'b0;
  logic feedback_input = 1'b0;
  logic crystal_input = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic freq_step_up, freq_step_down, low_power_request, device_hard_reset;
  logic nvm_reload_request, r_divider_sync, serial_three_wire_mode;
  logic [31:0] rdata;
  axi_resp_t bresp;
  axi_resp_t rresp;
  logic [1:0] pll_ref_select;
  logic [4:0] signal_absent_status;
  logic [4:0] run = 5'h1F;
  logic [1:0] gen_cnt = 2'h0;
  logic [31:0] seed = 32'd82;
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  int err_total = 0;
  int checked = 0;
  int up_n = 0;
  int dn_n = 0;
  int sync_n = 0;
  int nvm_n = 0;
  logic [7:0] tidx [0:15] = '{`REG_STEP, `REG_CTRL, `REG_REFSEL, `REG_WIRE, `REG_DET_EN,
    `REG_VAL_TIME, `REG_THR0_LO, `REG_THR0_HI, `REG_THR1_LO, `REG_THR1_HI, `REG_THR2_LO,
    `REG_THR2_HI, `REG_PDIV0, `REG_PDIV1, `REG_PDIV2, `REG_PDIVFB};
  logic [7:0] tmask [0:15] = '{8'h00, 8'h00, 8'h07, 8'h08, 8'h1F, 8'h3F, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F, 8'h0F};
  logic [7:0] trst [0:15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  clkgen_ctrl #(.VAL_CYCLES0(20), .VAL_CYCLES1(40), .VAL_CYCLES2(60), .VAL_CYCLES3(80)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .ref_choice_pin_high, .ref_choice_pin_low, .ext_sync_pin, .ref_input_zero,
    .ref_input_one, .ref_input_two, .feedback_input, .crystal_input, .freq_step_up,
    .freq_step_down, .low_power_request, .device_hard_reset, .nvm_reload_request,
    .r_divider_sync, .pll_ref_select, .serial_three_wire_mode, .signal_absent_status, .irq);

  always #2 aclk = ~aclk;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Input clocks at a sixth of aclk, well below the sampling limit
  always @(posedge aclk) begin
    gen_cnt <= (gen_cnt == 2'h2) ? 2'h0 : gen_cnt + 2'h1;
    if (gen_cnt == 2'h2) begin
      ref_input_zero <= ref_input_zero ^ run[0];
      ref_input_one <= ref_input_one ^ run[1];
      ref_input_two <= ref_input_two ^ run[2];
      feedback_input <= feedback_input ^ run[3];
      crystal_input <= crystal_input ^ run[4];
    end
  end

  always @(posedge aclk) begin
    if (freq_step_up === 1'b1) up_n <= up_n + 1;
    if (freq_step_down === 1'b1) dn_n <= dn_n + 1;
    if (r_divider_sync === 1'b1) sync_n <= sync_n + 1;
    if (nvm_reload_request === 1'b1) nvm_n <= nvm_n + 1;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check({rresp, rdata}, (rq.size() > 0) ? rq.pop_front() : 34'h3FFFFFFFF);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check(bresp, (bq.size() > 0) ? bq.pop_front() : 2'h3);
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s = 4'hF,
    input logic [1:0] er = `RESP_OKAY);
    int n;
    logic ad;
    logic wd;
    logic bd;
    @(posedge aclk);
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(er);
    while (!bd && n < 200) begin
      @(posedge aclk);
      n++;
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        bd = 1'b1;
        bready <= 1'b0;
      end
    end
    if (!bd) err_total++;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = `RESP_OKAY);
    int n;
    logic ad;
    logic dd;
    @(posedge aclk);
    n = 0;
    ad = 1'b0;
    dd = 1'b0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back({er, 24'h0, d});
    while (!dd && n < 200) begin
      @(posedge aclk);
      n++;
      if (!ad && arready === 1'b1) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        dd = 1'b1;
        rready <= 1'b0;
      end
    end
    if (!dd) err_total++;
  endtask

  task automatic wait_abs(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (signal_absent_status[b] !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    give_verdict();
  end

  initial begin
    logic [7:0] v;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 16; i++) rd(tidx[i], trst[i]);
    rd(8'h20, 8'h00, `RESP_SLVERR);
    wr(8'h20, 8'h5A, 4'hF, `RESP_SLVERR);
    for (int i = 2; i < 16; i++) begin
      v = 8'(rnd()) & tmask[i];
      wr(tidx[i], v);
      rd(tidx[i], v);
    end
    wr(`REG_DET_EN, 8'h00);
    wr(`REG_VAL_TIME, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'(`REG_THR0_LO + 2 * i), 8'h10);
      wr(8'(`REG_THR0_HI + 2 * i), 8'h00);
      wr(8'(`REG_PDIV0 + i), 8'h00);
    end
    wr(`REG_PDIVFB, 8'h00);
    // Strobes; counts are cumulative
    wr(`REG_STEP, 8'h01);
    wr(`REG_STEP, 8'h00);
    wr(`REG_STEP, 8'h02);
    wr(`REG_STEP, 8'h01);
    wr(`REG_STEP, 8'h01);
    repeat (3) @(posedge aclk);
    check(up_n, 3);
    check(dn_n, 1);
    rd(`REG_STEP, 8'h00);
    wr(`REG_CTRL, 8'h03);
    wr(`REG_STEP, 8'h01);
    repeat (3) @(posedge aclk);
    check({low_power_request, device_hard_reset}, 2'b11);
    check(nvm_n, 1);
    check(up_n, 3);
    rd(`REG_CTRL, 8'h03);
    wr(`REG_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    check({low_power_request, device_hard_reset}, 2'b00);
    wr(`REG_CTRL, 8'h04);
    rd(`REG_CTRL, 8'h00);
    ext_sync_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    ext_sync_pin <= 1'b0;
    check(sync_n, 2);
    wr(`REG_REFSEL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ref_choice_pin_high <= i[1];
      ref_choice_pin_low <= i[0];
      repeat (6) @(posedge aclk);
      check(pll_ref_select, i[1:0]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`REG_REFSEL, {5'h0, i[1:0], 1'b1});
      repeat (3) @(posedge aclk);
      check(pll_ref_select, i[1:0]);
    end
    wr(`REG_REFSEL, 8'h00, 4'hE);
    rd(`REG_REFSEL, 8'h07);
    wr(`REG_WIRE, 8'h08);
    repeat (3) @(posedge aclk);
    check(serial_three_wire_mode, 1'b1);
    wr(`REG_WIRE, 8'h00);
    repeat (3) @(posedge aclk);
    check(serial_three_wire_mode, 1'b0);
    // Let alarms from the random phase drain before clearing flags
    repeat (200) @(posedge aclk);
    wr(`REG_ABS_STICKY, 8'h00);
    wr(`REG_IRQ_CLEAR, 8'h1F);
    wr(`REG_IRQ_ENABLE, 8'h01);
    wr(`REG_DET_EN, 8'h01);
    run[0] <= 1'b0;
    wait_abs(0, 1'b1, 60);
    check(signal_absent_status, 5'h01);
    repeat (4) @(posedge aclk);
    check(irq, 1'b1);
    rd(`REG_ABS_STATUS, 8'h01);
    rd(`REG_IRQ_STATUS, 8'h01);
    rd(`REG_IRQ_CLEAR, 8'h00);
    rd(`REG_ABS_STICKY, 8'h01);
    wr(`REG_IRQ_ENABLE, 8'h00);
    repeat (4) @(posedge aclk);
    check(irq, 1'b0);
    wr(`REG_IRQ_ENABLE, 8'h01);
    run[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    check(signal_absent_status[0], 1'b1);
    check(irq, 1'b1);
    wait_abs(0, 1'b0, 60);
    check(signal_absent_status[0], 1'b0);
    rd(`REG_ABS_STICKY, 8'h01);
    wr(`REG_ABS_STICKY, 8'h00);
    rd(`REG_ABS_STICKY, 8'h00);
    wr(`REG_IRQ_CLEAR, 8'h01);
    repeat (4) @(posedge aclk);
    check(irq, 1'b0);
    // Divide by four stretches the edge gap past the threshold
    wr(`REG_VAL_TIME, 8'h0C);
    wr(`REG_PDIV1, 8'h02);
    wr(`REG_DET_EN, 8'h02);
    wait_abs(1, 1'b1, 100);
    check(signal_absent_status[1], 1'b1);
    wr(`REG_PDIV1, 8'h00);
    repeat (50) @(posedge aclk);
    check(signal_absent_status[1], 1'b1);
    wait_abs(1, 1'b0, 80);
    check(signal_absent_status[1], 1'b0);
    // Code 0x20 would bypass if unclamped; clamped to 16 a tick needs 65536 edges
    wr(`REG_PDIV1, 8'h20);
    wait_abs(1, 1'b1, 100);
    check(signal_absent_status[1], 1'b1);
    wr(`REG_DET_EN, 8'h00);
    run[4] <= 1'b0;
    wait_abs(4, 1'b1, 400);
    check(signal_absent_status[4], 1'b1);
    wr(`REG_DET_EN, 8'h10);
    wait_abs(4, 1'b0, 20);
    check(signal_absent_status[4], 1'b0);
    run[4] <= 1'b1;
    repeat (4) @(posedge aclk);
    give_verdict();
  end
endmodule // clkgen_ctrl_tb
`default_nettype wire
